// >>> design/ocmp_cfg.svh
// constants for the output compare channel: offsets, field positions, reset values
`ifndef OCMP_CFG_SVH
`define OCMP_CFG_SVH

`define OCMP_ADDR_W 2
`define OCMP_REG_SECONDARY 2'h0
`define OCMP_REG_PRIMARY 2'h1
`define OCMP_REG_CONTROL 2'h2
`define OCMP_REG_IRQ 2'h3

`define OCMP_CTL_MODE_LSB 0
`define OCMP_CTL_MODE_MSB 2
`define OCMP_CTL_TSEL_BIT 3
`define OCMP_CTL_FAULT_BIT 4
`define OCMP_CTL_SIDL_BIT 13

`define OCMP_IRQ_FLAG_BIT 0
`define OCMP_IRQ_EN_BIT 1

`define OCMP_CTL_RESET 16'h0000
`define OCMP_CMP_RESET 16'h0000
`define OCMP_MAX_CHANNELS 8
`define OCMP_OSC_PER_COUNT 4

`endif

// >>> design/ocmp_pkg.sv
// types shared by the output compare channel
package ocmp_pkg;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_FORCE_LOW = 3'h1,
    MODE_FORCE_HIGH = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_SINGLE = 3'h4,
    MODE_CONT = 3'h5,
    MODE_PWM = 3'h6,
    MODE_PWM_FAULT = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    PS_IDLE = 2'h0,
    PS_WAIT = 2'h1,
    PS_PULSE = 2'h3,
    PS_DONE = 2'h2
  } pulse_state_t;

endpackage : ocmp_pkg

// >>> design/compare_event_detect.sv
// timer selection and match detection for one compare channel
`timescale 1ns/1ns
module compare_event_detect #(
  parameter int TW = 16
) (
  // timer choice
  input wire logic sel,
  // first timer
  input wire logic [TW-1:0] first_count,
  input wire logic first_tick,
  // second timer
  input wire logic [TW-1:0] second_count,
  input wire logic second_tick,
  // compare values
  input wire logic [TW-1:0] primary_value,
  input wire logic [TW-1:0] secondary_value,
  // events
  output logic primary_hit,
  output logic secondary_hit,
  output logic boundary
);

  // a tick marks the cycle in which the count shows a freshly advanced value
  function automatic logic hit(input logic tick, input logic [TW-1:0] cnt, input logic [TW-1:0] val);
    hit = tick & (cnt == val);
  endfunction : hit

  wire logic [TW-1:0] count_sel;
  wire logic tick_sel;

  assign count_sel = sel ? second_count : first_count;
  assign tick_sel = sel ? second_tick : first_tick;
  assign primary_hit = hit(tick_sel, count_sel, primary_value);
  assign secondary_hit = hit(tick_sel, count_sel, secondary_value);
  // count back at zero after a period match: the period boundary
  assign boundary = hit(tick_sel, count_sel, {TW{1'b0}});

endmodule : compare_event_detect

// >>> design/fault_guard.sv
// latched fault state for fault-protected pwm
`timescale 1ns/1ns
module fault_guard (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // control
  input wire logic armed,
  input wire logic rearm,
  input wire logic fault_input_pin,
  // state
  output logic fault_r
);

  wire logic fault_nxt;

  // a live fault beats a rearm write in the same cycle
  assign fault_nxt = (armed & ~fault_input_pin) ? 1'b1 :
                     (rearm & fault_input_pin) ? 1'b0 : fault_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fault_r <= 1'b0;
    end else if (clk_en) begin
      fault_r <= fault_nxt;
    end
  end

endmodule : fault_guard

// >>> design/output_compare_pwm_channel.sv
// output compare / pwm channel with its control and compare registers
//
// Functional notes
// - one of up to eight channels, own control
// - control bit 3 picks timer, first default
// - modes 001/010/011 force low, high, toggle
// - wrap before match leaves the pin alone
// - mode 100 single pulse, 101 continuous pulses
// - primary match starts pulse, secondary ends it
// - single pulse re-armed only by writing 100
// - modes 110/111 pwm, buffered duty, primary read-only
// - mode 111 fault low tri-states the pin
// - control bit 4 shows a fault occurred
// - fault clears on removal plus mode rewrite
// - pwm period is (period+1) counts of timer
// - boundary sets pin, copies duty, flags timer
// - duty zero stays low, above period high
// - sleep holds the pin, resumes on wake
// - idle runs only with sidl and selected timer stop clear, timer on
// - non-pwm compare events set sticky flag
// - pwm never sets the compare flag
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "ocmp_cfg.svh"
module output_compare_pwm_channel
  import ocmp_pkg::*;
#(
  parameter int CHANNEL_INDEX = 0,
  parameter int TW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [`OCMP_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // first timer
  input wire logic [TW-1:0] first_timer_count,
  input wire logic first_timer_tick,
  input wire logic first_timer_run_bit,
  input wire logic first_timer_idle_stop_bit,
  // second timer
  input wire logic [TW-1:0] second_timer_count,
  input wire logic second_timer_tick,
  input wire logic second_timer_run_bit,
  input wire logic second_timer_idle_stop_bit,
  // power state
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // fault
  input wire logic fault_input_pin,
  // pin
  output logic compare_output_pin,
  output logic compare_output_oe,
  // interrupt requests
  output logic compare_irq,
  output logic first_timer_irq_set,
  output logic second_timer_irq_set
);

  // one channel per instance; the index only matters for the count limit
  if (CHANNEL_INDEX < 0 || CHANNEL_INDEX >= `OCMP_MAX_CHANNELS) begin : g_bad_index
    $error("channel index out of range");
  end
  if (TW < 2 || TW > 16) begin : g_bad_width
    $error("timer width must be 2 to 16");
  end

  // registers
  mode_t mode_r;
  logic tsel_r;
  logic sidl_r;
  logic [TW-1:0] primary_r;
  logic [TW-1:0] secondary_r;
  logic irq_flag_r;
  logic irq_en_r;
  pulse_state_t pstate_r;
  logic pin_r;
  logic oe_r;
  logic irq_r;
  logic t1_set_r;
  logic t2_set_r;
  logic [15:0] rdata_r;
  logic fault_r;

  // decode
  wire logic wr_ctl;
  wire logic wr_pri;
  wire logic wr_sec;
  wire logic wr_irq;
  wire mode_t wmode;
  wire logic is_pwm;
  wire logic is_dual;
  wire logic is_simple;
  wire logic wmode_pwm;
  wire logic wmode_pulse;

  // mode groups, asked of the mode in force and of the mode being written
  function automatic logic pulse_mode(input mode_t m);
    pulse_mode = (m == MODE_SINGLE) | (m == MODE_CONT);
  endfunction : pulse_mode

  function automatic logic pwm_mode(input mode_t m);
    pwm_mode = (m == MODE_PWM) | (m == MODE_PWM_FAULT);
  endfunction : pwm_mode

  assign wr_ctl = reg_wr & (reg_addr == `OCMP_REG_CONTROL);
  assign wr_pri = reg_wr & (reg_addr == `OCMP_REG_PRIMARY);
  assign wr_sec = reg_wr & (reg_addr == `OCMP_REG_SECONDARY);
  assign wr_irq = reg_wr & (reg_addr == `OCMP_REG_IRQ);
  assign wmode = mode_t'(reg_wdata[`OCMP_CTL_MODE_MSB:`OCMP_CTL_MODE_LSB]);
  assign is_pwm = pwm_mode(mode_r);
  assign is_dual = pulse_mode(mode_r);
  assign is_simple = (mode_r == MODE_FORCE_LOW) | (mode_r == MODE_FORCE_HIGH) | (mode_r == MODE_TOGGLE);
  assign wmode_pwm = pwm_mode(wmode);
  assign wmode_pulse = pulse_mode(wmode);

  // engine gating: sleep stops every match event, idle only with sidl and the selected timer's stop bit clear and that timer running
  wire logic sel_run;
  wire logic sel_timer_idle_stop_bit;
  wire logic engine_run;

  assign sel_run = tsel_r ? second_timer_run_bit : first_timer_run_bit;
  assign sel_timer_idle_stop_bit = tsel_r ? second_timer_idle_stop_bit : first_timer_idle_stop_bit;
  assign engine_run = clk_en & ~cpu_sleep
                      & ~(cpu_idle & (sidl_r | ~sel_run | sel_timer_idle_stop_bit));

  // events
  wire logic prim_hit;
  wire logic sec_hit;
  wire logic boundary;

  compare_event_detect #(
    .TW(TW)
  ) u_detect (
    .sel(tsel_r),
    .first_count(first_timer_count),
    .first_tick(first_timer_tick),
    .second_count(second_timer_count),
    .second_tick(second_timer_tick),
    .primary_value(primary_r),
    .secondary_value(secondary_r),
    .primary_hit(prim_hit),
    .secondary_hit(sec_hit),
    .boundary(boundary)
  );

  fault_guard u_fault (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .armed(mode_r == MODE_PWM_FAULT),
    .rearm(wr_ctl & wmode_pwm),
    .fault_input_pin(fault_input_pin),
    .fault_r(fault_r)
  );

  // match effects
  wire logic ev_simple;
  wire logic ev_start;
  wire logic ev_stop;
  wire logic ev_bound;
  wire logic cmp_event;
  wire logic ev_duty_end;

  // the timer wrapping short of the value simply never hits
  assign ev_simple = engine_run & is_simple & prim_hit;
  assign ev_start = engine_run & is_dual & (pstate_r == PS_WAIT) & prim_hit;
  assign ev_stop = engine_run & is_dual & (pstate_r == PS_PULSE) & sec_hit;
  assign ev_bound = engine_run & is_pwm & boundary;
  // duty match ends the high part; a same-cycle boundary is served first
  assign ev_duty_end = engine_run & is_pwm & prim_hit;
  assign cmp_event = ev_simple | ev_start | ev_stop;

  // pulse sequencer
  pulse_state_t pstate_nxt;

  always_comb begin
    pstate_nxt = pstate_r;
    if (wr_ctl) begin
      pstate_nxt = wmode_pulse ? PS_WAIT : PS_IDLE;
    end else begin
      unique case (pstate_r)
        PS_IDLE: pstate_nxt = PS_IDLE;
        PS_WAIT: begin
          if (ev_start) begin
            pstate_nxt = PS_PULSE;
          end
        end
        PS_PULSE: begin
          if (ev_stop) begin
            pstate_nxt = (mode_r == MODE_SINGLE) ? PS_DONE : PS_WAIT;
          end
        end
        PS_DONE: pstate_nxt = PS_DONE;
      endcase
    end
  end

  // pin level
  logic pin_nxt;

  always_comb begin
    pin_nxt = pin_r;
    if (wr_ctl) begin
      // entering a pulse mode or off starts low; other modes keep the level
      if ((wmode == MODE_OFF) | wmode_pulse) begin
        pin_nxt = 1'b0;
      end
    end else if (ev_simple) begin
      unique case (mode_r)
        MODE_FORCE_LOW: pin_nxt = 1'b0;
        MODE_FORCE_HIGH: pin_nxt = 1'b1;
        default: pin_nxt = ~pin_r;
      endcase
    end else if (ev_start) begin
      pin_nxt = 1'b1;
    end else if (ev_stop) begin
      pin_nxt = 1'b0;
    end else if (ev_bound) begin
      // new duty of zero keeps it low; above period it never hits, so stays high
      pin_nxt = (secondary_r != {TW{1'b0}});
    end else if (ev_duty_end) begin
      pin_nxt = 1'b0;
    end
  end

  // drive enable follows the mode that will be in force next cycle
  wire mode_t mode_nxt;
  wire logic oe_nxt;
  wire logic fault_block;

  assign mode_nxt = wr_ctl ? wmode : mode_r;
  // a latched fault still blocks in the rearm cycle, so the pin returns one cycle late
  assign fault_block = (mode_nxt == MODE_PWM_FAULT) & (fault_r | ~fault_input_pin);
  assign oe_nxt = (mode_nxt != MODE_OFF) & ~fault_block;

  // interrupt flag: a new event wins over a clearing write
  wire logic irq_flag_nxt;

  assign irq_flag_nxt = cmp_event | (wr_irq ? reg_wdata[`OCMP_IRQ_FLAG_BIT] & irq_flag_r : irq_flag_r);

  // read data
  wire logic [15:0] ctl_view;
  wire logic [15:0] rdata_nxt;

  assign ctl_view = {2'h0, sidl_r, 8'h00, fault_r, tsel_r, mode_r};
  assign rdata_nxt = (reg_addr == `OCMP_REG_SECONDARY) ? 16'(secondary_r) :
                     (reg_addr == `OCMP_REG_PRIMARY) ? 16'(primary_r) :
                     (reg_addr == `OCMP_REG_CONTROL) ? ctl_view :
                     {14'h0000, irq_en_r, irq_flag_r};

  // control, interrupt enable and secondary compare registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_OFF;
      tsel_r <= 1'b0;
      sidl_r <= 1'b0;
      irq_en_r <= 1'b0;
      secondary_r <= TW'(`OCMP_CMP_RESET);
    end else if (clk_en) begin
      if (wr_ctl) begin
        mode_r <= wmode;
        tsel_r <= reg_wdata[`OCMP_CTL_TSEL_BIT];
        sidl_r <= reg_wdata[`OCMP_CTL_SIDL_BIT];
      end
      if (wr_irq) begin
        irq_en_r <= reg_wdata[`OCMP_IRQ_EN_BIT];
      end
      if (wr_sec) begin
        secondary_r <= reg_wdata[TW-1:0];
      end
    end
  end

  // primary is software-written outside pwm, a duty latch inside it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      primary_r <= TW'(`OCMP_CMP_RESET);
    end else if (clk_en) begin
      if (ev_bound) begin
        primary_r <= secondary_r;
      end else if (wr_pri & ~is_pwm) begin
        primary_r <= reg_wdata[TW-1:0];
      end
    end
  end

  // engine state and pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pstate_r <= PS_IDLE;
      pin_r <= 1'b0;
      oe_r <= 1'b0;
      irq_flag_r <= 1'b0;
    end else if (clk_en) begin
      pstate_r <= pstate_nxt;
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
      irq_flag_r <= irq_flag_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
      t1_set_r <= 1'b0;
      t2_set_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else if (clk_en) begin
      irq_r <= irq_flag_nxt & (wr_irq ? reg_wdata[`OCMP_IRQ_EN_BIT] : irq_en_r);
      t1_set_r <= ev_bound & ~tsel_r;
      t2_set_r <= ev_bound & tsel_r;
      if (reg_rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign compare_output_pin = pin_r;
  assign compare_output_oe = oe_r;
  assign compare_irq = irq_r;
  assign first_timer_irq_set = t1_set_r;
  assign second_timer_irq_set = t2_set_r;
  assign reg_rdata = rdata_r;

endmodule : output_compare_pwm_channel

// >>> verif/ocmp_checker.sv
// port assertions for the output compare channel
`timescale 1ns/1ns
`include "ocmp_cfg.svh"
module ocmp_checker #(
  parameter int TW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [`OCMP_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  // timers
  input wire logic [TW-1:0] first_timer_count,
  input wire logic first_timer_tick,
  input wire logic [TW-1:0] second_timer_count,
  input wire logic second_timer_tick,
  input wire logic first_timer_run_bit,
  input wire logic first_timer_idle_stop_bit,
  input wire logic second_timer_run_bit,
  input wire logic second_timer_idle_stop_bit,
  // power and fault
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic fault_input_pin,
  // outputs
  input wire logic compare_output_pin,
  input wire logic compare_output_oe,
  input wire logic first_timer_irq_set
);
  logic [2:0] mode_r;
  logic tsel_r;
  logic sidl_r;
  logic [TW-1:0] pri_r;
  logic [TW-1:0] sec_r;
  wire ctl_wr = clk_en && reg_wr && reg_addr == `OCMP_REG_CONTROL;
  // idle freezes only with a stop bit set or the selected timer off
  wire sel_on = tsel_r ? second_timer_run_bit : first_timer_run_bit;
  wire sel_stop = tsel_r ? second_timer_idle_stop_bit : first_timer_idle_stop_bit;
  wire run = clk_en && !cpu_sleep && !(cpu_idle && (sidl_r || !sel_on || sel_stop));
  wire [TW-1:0] cnt = tsel_r ? second_timer_count : first_timer_count;
  wire tk = run && (tsel_r ? second_timer_tick : first_timer_tick);
  wire hit_p = tk && cnt == pri_r;
  wire hit_s = tk && cnt == sec_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= 3'h0;
      tsel_r <= 1'b0;
      sidl_r <= 1'b0;
      pri_r <= '0;
      sec_r <= '0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `OCMP_REG_CONTROL) begin
        mode_r <= reg_wdata[2:0];
        tsel_r <= reg_wdata[3];
        sidl_r <= reg_wdata[13];
      end
      if (reg_addr == `OCMP_REG_PRIMARY && mode_r[2:1] != 2'b11) begin
        pri_r <= reg_wdata[TW-1:0];
      end
      if (reg_addr == `OCMP_REG_SECONDARY) begin
        sec_r <= reg_wdata[TW-1:0];
      end
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  property p_off;
    mode_r == 3'h0 && $stable(mode_r) && !ctl_wr && run |=> !compare_output_oe && !compare_output_pin;
  endproperty
  a_off: assert property (p_off) else $error("pin active while channel off");
  property p_force;
    (mode_r == 3'h1 || mode_r == 3'h2) && $stable(mode_r) && hit_p |=> compare_output_pin == $past(mode_r[1]);
  endproperty
  a_force: assert property (p_force) else $error("forced level wrong after match");
  property p_toggle;
    mode_r == 3'h3 && $stable(mode_r) && hit_p |=> compare_output_pin != $past(compare_output_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");
  property p_wrap;
    mode_r != 3'h0 && !mode_r[2] && $stable(mode_r) && tk && cnt == '0 && pri_r != '0 |=> $stable(compare_output_pin);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pin moved on wrap");
  property p_dual_stop;
    mode_r[2:1] == 2'b10 && $stable(mode_r) && hit_s && !hit_p |=> !compare_output_pin;
  endproperty
  a_dual_stop: assert property (p_dual_stop) else $error("pulse not ended on second match");
  property p_fault_tri;
    mode_r == 3'h7 && run && !fault_input_pin |=> !compare_output_oe;
  endproperty
  a_fault_tri: assert property (p_fault_tri) else $error("pin still driven in fault");
  property p_fault_hold;
    mode_r == 3'h7 && $past(mode_r) == 3'h7 && !compare_output_oe && !ctl_wr && !$past(ctl_wr) |=> !compare_output_oe;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault left without rewrite");
  property p_period_flag;
    mode_r[2:1] == 2'b11 && !tsel_r && tk && cnt == '0 |-> ##[1:2] first_timer_irq_set;
  endproperty
  a_period_flag: assert property (p_period_flag) else $error("no timer flag at period");
  property p_sleep;
    cpu_sleep && $past(cpu_sleep) |-> $stable(compare_output_pin);
  endproperty
  a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
endmodule : ocmp_checker

// >>> verif/tb_top.sv
// self-checking bench for the output compare channel
`timescale 1ns/1ns
`include "ocmp_cfg.svh"
module tb_top import ocmp_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] rv;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_idle = 1'b0, cpu_sleep = 1'b0, fault_input_pin = 1'b1;
  logic [15:0] first_timer_count = 16'h0000, second_timer_count = 16'h0000;
  logic first_timer_tick = 1'b0, second_timer_tick = 1'b0;
  logic first_timer_run_bit = 1'b1, second_timer_run_bit = 1'b1;
  logic first_timer_idle_stop_bit = 1'b0, second_timer_idle_stop_bit = 1'b0;
  logic compare_output_pin, compare_output_oe, compare_irq, first_timer_irq_set, second_timer_irq_set;
  int fails = 0, n_tests = 0, pulses = 0;
  output_compare_pwm_channel dut_u (.clk_sys, .rst_b, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .first_timer_count, .first_timer_tick, .first_timer_run_bit, .first_timer_idle_stop_bit,
    .second_timer_count, .second_timer_tick, .second_timer_run_bit, .second_timer_idle_stop_bit,
    .cpu_idle, .cpu_sleep, .fault_input_pin, .compare_output_pin, .compare_output_oe, .compare_irq,
    .first_timer_irq_set, .second_timer_irq_set);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic pin(input logic e);
    chk("pin", {15'h0, compare_output_pin}, {15'h0, e});
  endtask : pin
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask : rd
  // one advance of a timer; period flag pulses then counted, first timer as 1, second as 2
  task automatic tick(input logic s, input logic [15:0] c);
    @(posedge clk_sys);
    if (s) begin
      second_timer_count <= c;
      second_timer_tick <= 1'b1;
    end else begin
      first_timer_count <= c;
      first_timer_tick <= 1'b1;
    end
    @(posedge clk_sys);
    first_timer_tick <= 1'b0;
    second_timer_tick <= 1'b0;
    pulses = 0;
    repeat (3) @(negedge clk_sys) pulses += {second_timer_irq_set, first_timer_irq_set};
  endtask : tick
  initial begin
    #1000000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(`OCMP_REG_CONTROL);
    chk("control reset", rv, `OCMP_CTL_RESET);
    wr(`OCMP_REG_CONTROL, 16'h2018);
    rd(`OCMP_REG_CONTROL);
    chk("control bits", rv, 16'h2008);
    chk("oe off", {15'h0, compare_output_oe}, 16'h0000);
    wr(`OCMP_REG_PRIMARY, 16'h0005);
    wr(`OCMP_REG_IRQ, 16'h0002);
    for (int m = 1; m <= 3; m++) begin
      wr(`OCMP_REG_CONTROL, {13'h0, m[2:0]});
      tick(1'b0, 16'h0000);
      pin(m == 3);
      tick(1'b0, 16'h0005);
      pin(m == 2);
      chk("compare irq", {15'h0, compare_irq}, 16'h0001);
    end
    // toggle on the second timer; idle runs only with sidl and the second timer's stop bit clear and that timer on
    wr(`OCMP_REG_CONTROL, 16'h200b);
    tick(1'b0, 16'h0005);
    pin(1'b0);
    @(posedge clk_sys);
    cpu_idle <= 1'b1;
    tick(1'b1, 16'h0005);
    pin(1'b0);
    wr(`OCMP_REG_CONTROL, 16'h000b);
    tick(1'b1, 16'h0005);
    pin(1'b1);
    @(posedge clk_sys);
    second_timer_idle_stop_bit <= 1'b1;
    tick(1'b1, 16'h0005);
    pin(1'b1);
    @(posedge clk_sys);
    second_timer_idle_stop_bit <= 1'b0;
    second_timer_run_bit <= 1'b0;
    tick(1'b1, 16'h0005);
    pin(1'b1);
    @(posedge clk_sys);
    cpu_idle <= 1'b0;
    second_timer_run_bit <= 1'b1;
    tick(1'b1, 16'h0005);
    pin(1'b0);
    wr(`OCMP_REG_PRIMARY, 16'h0003);
    wr(`OCMP_REG_SECONDARY, 16'h0007);
    for (int k = 0; k < 2; k++) begin
      wr(`OCMP_REG_CONTROL, {13'h0, MODE_SINGLE});
      tick(1'b0, 16'h0003);
      pin(1'b1);
      tick(1'b0, 16'h0007);
      pin(1'b0);
      tick(1'b0, 16'h0003);
      pin(1'b0);
    end
    wr(`OCMP_REG_CONTROL, {13'h0, MODE_CONT});
    repeat (2) begin
      tick(1'b0, 16'h0003);
      pin(1'b1);
      tick(1'b0, 16'h0007);
      pin(1'b0);
    end
    wr(`OCMP_REG_IRQ, 16'h0002);
    wr(`OCMP_REG_SECONDARY, 16'h0004);
    wr(`OCMP_REG_CONTROL, {13'h0, MODE_PWM});
    wr(`OCMP_REG_PRIMARY, 16'h0009);
    tick(1'b0, 16'h0000);
    pin(1'b1);
    chk("period flag", pulses[15:0], 16'h0001);
    rd(`OCMP_REG_PRIMARY);
    chk("duty latch", rv, 16'h0004);
    tick(1'b0, 16'h0004);
    pin(1'b0);
    chk("compare irq", {15'h0, compare_irq}, 16'h0000);
    wr(`OCMP_REG_SECONDARY, 16'h0000);
    tick(1'b0, 16'h0000);
    pin(1'b0);
    wr(`OCMP_REG_SECONDARY, 16'hffff);
    tick(1'b0, 16'h0000);
    tick(1'b0, 16'h0004);
    pin(1'b1);
    wr(`OCMP_REG_SECONDARY, 16'h0004);
    tick(1'b0, 16'h0000);
    @(posedge clk_sys);
    cpu_sleep <= 1'b1;
    tick(1'b0, 16'h0004);
    pin(1'b1);
    @(posedge clk_sys);
    cpu_sleep <= 1'b0;
    tick(1'b0, 16'h0004);
    pin(1'b0);
    wr(`OCMP_REG_CONTROL, 16'h000e);
    tick(1'b1, 16'h0000);
    chk("second period flag", pulses[15:0], 16'h0002);
    pin(1'b1);
    wr(`OCMP_REG_CONTROL, {13'h0, MODE_PWM_FAULT});
    tick(1'b0, 16'h0000);
    chk("oe", {15'h0, compare_output_oe}, 16'h0001);
    @(posedge clk_sys) fault_input_pin <= 1'b0;
    @(posedge clk_sys) fault_input_pin <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("oe", {15'h0, compare_output_oe}, 16'h0000);
    rd(`OCMP_REG_CONTROL);
    chk("fault bit", rv, 16'h0017);
    chk("oe", {15'h0, compare_output_oe}, 16'h0000);
    wr(`OCMP_REG_CONTROL, {13'h0, MODE_PWM_FAULT});
    repeat (2) @(negedge clk_sys);
    chk("oe", {15'h0, compare_output_oe}, 16'h0001);
    finish_test();
  end
endmodule : tb_top
bind output_compare_pwm_channel ocmp_checker #(.TW(TW)) chk_u (.clk_sys, .rst_b, .clk_en, .reg_addr, .reg_wdata,
  .reg_wr, .first_timer_count, .first_timer_tick, .second_timer_count, .second_timer_tick, .first_timer_run_bit,
  .first_timer_idle_stop_bit, .second_timer_run_bit, .second_timer_idle_stop_bit, .cpu_idle, .cpu_sleep,
  .fault_input_pin, .compare_output_pin, .compare_output_oe, .first_timer_irq_set);
